//--- core/spi_port_pkg.sv
package spi_port_pkg;

	// ----------------------------------------------------------------
	// byte framing
	// ----------------------------------------------------------------
	localparam int BYTE_W = 8;
	localparam int SYNC_STAGES = 2;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [BYTE_W-1:0] TX_FILL_RST = 8'hFF;
	localparam logic [BYTE_W-1:0] RX_DATA_RST = 8'h00;
	localparam logic MODE_BIT_RST = 1'h0;
	localparam logic SELECT_IDLE = 1'h1;

	// ----------------------------------------------------------------
	// synchroniser bundle bit positions
	// ----------------------------------------------------------------
	localparam int SYN_SEL = 0;
	localparam int SYN_RX_TGL = 1;
	localparam int SYN_TAKE_TGL = 2;
	localparam int SYN_POL = 3;
	localparam int SYN_PHA = 4;
	localparam int SYN_W = 5;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CORE_PERIOD_PS = 5000;
	localparam int SCLK_MAX_LOCKED_MHZ = 20;
	localparam int SCLK_MAX_UNLOCKED_MHZ = 3;
	localparam int OUT_RELEASE_NS = 10;
	// release is taken asynchronously from the select pin; this is the budget in core cycles
	localparam int OUT_RELEASE_CYCLES = (OUT_RELEASE_NS * 1000 / CORE_PERIOD_PS) < 1 ? 1 :
		(OUT_RELEASE_NS * 1000 / CORE_PERIOD_PS);

endpackage : spi_port_pkg

//--- core/bit_sync.sv
`timescale 1ns/100ps

module bit_sync #(
	parameter int WIDTH = 1,
	parameter int STAGES = 2
) (
	input wire logic core_clk_i,
	input wire logic clk_en_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	if (STAGES < 2) begin : g_bad_stages
		$error("bit_sync needs at least two stages");
	end
	if (WIDTH < 1) begin : g_bad_width
		$error("bit_sync needs a width of at least one");
	end

	// ----------------------------------------------------------------
	// flop chain, only the next stage reads each stage, and only sync_o reads the last
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] stage_r [STAGES];

	always_ff @(posedge core_clk_i) begin
		if (clk_en_i) begin
			stage_r[0] <= async_i;
		end
	end

	for (genvar s = 1; s < STAGES; s++) begin : g_stage
		always_ff @(posedge core_clk_i) begin
			if (clk_en_i) begin
				stage_r[s] <= stage_r[s-1];
			end
		end
	end

	assign sync_o = stage_r[STAGES-1];

endmodule : bit_sync

//--- core/spi_slave_port.sv
// Operation
// - device is target only; never drives serial clock or starts transfers.
// - all four polarity and phase combinations are supported.
// - single or many consecutive bytes may pass within one select period.
// - each byte shifts most significant bit first, least significant last.
// - select low starts a transfer, select high ends it.
// - serial output released within 10 ns after select returns high.
// - two strap pins choose the serial mode, polarity and phase.
// - straps sampled once after each reset release, then ignored as plain inputs.
// - select falling edge also raises a wake-up event.
`timescale 1ns/100ps

module spi_slave_port #(
	parameter int DATA_W = spi_port_pkg::BYTE_W
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	input wire logic serial_clock_in_i,
	input wire logic port_select_low_i,
	input wire logic host_serial_in_i,
	output logic device_serial_out_o,
	output logic device_serial_out_oe_o,
	input wire logic polarity_strap_pin_i,
	input wire logic phase_strap_pin_i,
	output logic clock_polarity_select_o,
	output logic clock_phase_select_o,
	output logic mode_valid_o,
	output logic frame_active_o,
	output logic wake_o,
	output logic [DATA_W-1:0] rx_data_o,
	output logic rx_valid_o,
	input wire logic [DATA_W-1:0] tx_data_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	output logic tx_underrun_o
);

	localparam int CNT_W = $clog2(DATA_W);
	localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(DATA_W - 1);
	localparam logic [CNT_W-1:0] FIRST_BIT = '0;

	if (DATA_W < 2 || (1 << CNT_W) != DATA_W) begin : g_bad_width
		$error("spi_slave_port byte width must be a power of two, at least two");
	end

	// ----------------------------------------------------------------
	// mode straps and link clock
	// ----------------------------------------------------------------
	logic pol_r;
	logic pha_r;
	logic mode_done_r;
	logic link_clk;

	// serial clock only ever comes in from the host, port never drives it
	// idle level of link_clk equals the phase bit; its rising edge samples
	assign link_clk = serial_clock_in_i ^ (pol_r ^ pha_r);

	// ----------------------------------------------------------------
	// link domain: sample side
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] bit_cnt_r;
	logic rx_tgl_r;
	logic take_tgl_r;
	logic [DATA_W-1:0] rx_sr_r;
	logic [DATA_W-1:0] rx_hold_r;
	logic [DATA_W-1:0] tx_sr_r;
	logic [DATA_W-1:0] tx_stage_r;

	// frame state cleared by select high so a frame never leans on a later clock
	always_ff @(posedge link_clk or posedge port_select_low_i) begin
		if (port_select_low_i) begin
			bit_cnt_r <= FIRST_BIT;
		end else begin
			bit_cnt_r <= bit_cnt_r + CNT_W'(1);
		end
	end

	always_ff @(posedge link_clk or posedge port_select_low_i) begin
		if (port_select_low_i) begin
			rx_tgl_r <= 1'b0;
		end else if (bit_cnt_r == LAST_BIT) begin
			rx_tgl_r <= ~rx_tgl_r;
		end
	end

	always_ff @(posedge link_clk or posedge port_select_low_i) begin
		if (port_select_low_i) begin
			take_tgl_r <= 1'b0;
		end else if (bit_cnt_r == FIRST_BIT) begin
			take_tgl_r <= ~take_tgl_r;
		end
	end

	// msb arrives first, so shift toward the top
	always_ff @(posedge link_clk) begin
		rx_sr_r <= {rx_sr_r[DATA_W-2:0], host_serial_in_i};
	end

	always_ff @(posedge link_clk) begin
		if (bit_cnt_r == LAST_BIT) begin
			rx_hold_r <= {rx_sr_r[DATA_W-2:0], host_serial_in_i};
		end
	end

	// staged byte is copied at the first sample; core refills it meanwhile
	always_ff @(posedge link_clk) begin
		if (bit_cnt_r == FIRST_BIT) begin
			tx_sr_r <= tx_stage_r;
		end
	end

	// ----------------------------------------------------------------
	// link domain: launch side
	// ----------------------------------------------------------------
	logic out_bit_r;
	logic first_r;
	logic launch_bit;

	assign launch_bit = (bit_cnt_r == FIRST_BIT) ? tx_stage_r[DATA_W-1] : tx_sr_r[LAST_BIT - bit_cnt_r];

	always_ff @(negedge link_clk or posedge port_select_low_i) begin
		if (port_select_low_i) begin
			out_bit_r <= 1'b0;
		end else begin
			out_bit_r <= launch_bit;
		end
	end

	always_ff @(negedge link_clk or posedge port_select_low_i) begin
		if (port_select_low_i) begin
			first_r <= 1'b1;
		end else begin
			first_r <= 1'b0;
		end
	end

	// phase 0 needs the msb on the line before any clock edge
	assign device_serial_out_o = (!pha_r && first_r) ? tx_stage_r[DATA_W-1] : out_bit_r;

	// ----------------------------------------------------------------
	// crossing into the core domain
	// ----------------------------------------------------------------
	logic [spi_port_pkg::SYN_W-1:0] syn_in;
	logic [spi_port_pkg::SYN_W-1:0] syn_out;
	logic sel_s;
	logic rx_tgl_s;
	logic take_tgl_s;

	always_comb begin
		syn_in = '0;
		syn_in[spi_port_pkg::SYN_SEL] = port_select_low_i;
		syn_in[spi_port_pkg::SYN_RX_TGL] = rx_tgl_r;
		syn_in[spi_port_pkg::SYN_TAKE_TGL] = take_tgl_r;
		syn_in[spi_port_pkg::SYN_POL] = polarity_strap_pin_i;
		syn_in[spi_port_pkg::SYN_PHA] = phase_strap_pin_i;
	end

	bit_sync #(
		.WIDTH(spi_port_pkg::SYN_W),
		.STAGES(spi_port_pkg::SYNC_STAGES)
	) u_sync (
		.core_clk_i(core_clk_i),
		.clk_en_i(clk_en_i),
		.async_i(syn_in),
		.sync_o(syn_out)
	);

	assign sel_s = syn_out[spi_port_pkg::SYN_SEL];
	assign rx_tgl_s = syn_out[spi_port_pkg::SYN_RX_TGL];
	assign take_tgl_s = syn_out[spi_port_pkg::SYN_TAKE_TGL];

	// ----------------------------------------------------------------
	// strap capture after reset release
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			pol_r <= spi_port_pkg::MODE_BIT_RST;
			pha_r <= spi_port_pkg::MODE_BIT_RST;
			mode_done_r <= 1'b0;
		end else if (clk_en_i && !mode_done_r) begin
			pol_r <= syn_out[spi_port_pkg::SYN_POL];
			pha_r <= syn_out[spi_port_pkg::SYN_PHA];
			mode_done_r <= 1'b1;
		end
	end

	assign clock_polarity_select_o = pol_r;
	assign clock_phase_select_o = pha_r;
	assign mode_valid_o = mode_done_r;

	// ----------------------------------------------------------------
	// output enable, released straight from the select pin
	// ----------------------------------------------------------------
	logic oe_r;

	always_ff @(posedge core_clk_i or posedge port_select_low_i) begin
		if (port_select_low_i) begin
			oe_r <= 1'b0;
		end else if (!reset_n_i) begin
			oe_r <= 1'b0;
		end else if (clk_en_i) begin
			oe_r <= !sel_s && mode_done_r;
		end
	end

	assign device_serial_out_oe_o = oe_r;

	// ----------------------------------------------------------------
	// frame tracking and wake event
	// ----------------------------------------------------------------
	logic sel_prev_r;
	logic frame_r;
	logic wake_r;

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			sel_prev_r <= spi_port_pkg::SELECT_IDLE;
			frame_r <= 1'b0;
			wake_r <= 1'b0;
		end else if (clk_en_i) begin
			sel_prev_r <= sel_s;
			frame_r <= !sel_s;
			wake_r <= sel_prev_r && !sel_s;
		end
	end

	assign frame_active_o = frame_r;
	assign wake_o = wake_r;

	// ----------------------------------------------------------------
	// received bytes
	// ----------------------------------------------------------------
	logic rx_prev_r;
	logic [DATA_W-1:0] rx_data_r;
	logic rx_valid_r;

	// while idle the tracker follows the toggle, hiding the clear by select
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			rx_prev_r <= 1'b0;
			rx_valid_r <= 1'b0;
			rx_data_r <= DATA_W'(spi_port_pkg::RX_DATA_RST);
		end else if (clk_en_i) begin
			rx_prev_r <= rx_tgl_s;
			rx_valid_r <= !sel_s && (rx_tgl_s != rx_prev_r);
			if (!sel_s && rx_tgl_s != rx_prev_r) begin
				rx_data_r <= rx_hold_r;
			end
		end
	end

	assign rx_data_o = rx_data_r;
	assign rx_valid_o = rx_valid_r;

	// ----------------------------------------------------------------
	// transmit staging
	// ----------------------------------------------------------------
	logic take_prev_r;
	logic tx_ready_r;
	logic underrun_r;
	logic take_evt;

	assign take_evt = !sel_s && (take_tgl_s != take_prev_r);

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			take_prev_r <= 1'b0;
		end else if (clk_en_i) begin
			take_prev_r <= take_tgl_s;
		end
	end

	// a fresh load wins over a take seen in the same cycle: link copied the old byte
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			tx_ready_r <= 1'b1;
			tx_stage_r <= DATA_W'(spi_port_pkg::TX_FILL_RST);
		end else if (clk_en_i) begin
			if (tx_valid_i && tx_ready_r) begin
				tx_stage_r <= tx_data_i;
				tx_ready_r <= 1'b0;
			end else if (take_evt) begin
				tx_ready_r <= 1'b1;
			end
		end
	end

	// sticky per frame: a byte went out that the user never refreshed
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			underrun_r <= 1'b0;
		end else if (clk_en_i) begin
			if (take_evt && tx_ready_r && !tx_valid_i) begin
				underrun_r <= 1'b1;
			end else if (sel_prev_r && !sel_s) begin
				underrun_r <= 1'b0;
			end
		end
	end

	assign tx_ready_o = tx_ready_r;
	assign tx_underrun_o = underrun_r;

endmodule : spi_slave_port

//--- verif/spi_port_sva.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module spi_port_sva (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	input wire logic port_select_low_i,
	input wire logic polarity_strap_pin_i,
	input wire logic phase_strap_pin_i,
	input wire logic device_serial_out_oe_o,
	input wire logic clock_polarity_select_o,
	input wire logic clock_phase_select_o,
	input wire logic mode_valid_o,
	input wire logic frame_active_o,
	input wire logic wake_o,
	input wire logic rx_valid_o,
	input wire logic tx_valid_i,
	input wire logic tx_ready_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!reset_n_i);
	a_oe_idle_off: assert property (port_select_low_i |-> !device_serial_out_oe_o)
		else $error("oe high while deselected");
	a_oe_rise_bound: assert property (
		$fell(port_select_low_i) |-> ##[1:6] (device_serial_out_oe_o || port_select_low_i))
		else $error("oe late after select");
	a_frame_up: assert property ($fell(port_select_low_i) |-> ##[1:4] frame_active_o)
		else $error("frame not flagged");
	a_wake_on_fall: assert property ($fell(port_select_low_i) |-> ##[1:4] wake_o)
		else $error("no wake on select");
	a_wake_one_pulse: assert property (wake_o |=> !wake_o)
		else $error("wake longer than one cycle");
	a_rx_one_pulse: assert property (rx_valid_o |=> !rx_valid_o)
		else $error("rx valid longer than one cycle");
	a_mode_take: assert property ($rose(reset_n_i) && clk_en_i |=> mode_valid_o &&
		clock_polarity_select_o == $past(polarity_strap_pin_i) && clock_phase_select_o == $past(phase_strap_pin_i))
		else $error("straps not captured");
	a_mode_hold: assert property (mode_valid_o |=> mode_valid_o &&
		$stable(clock_polarity_select_o) && $stable(clock_phase_select_o))
		else $error("mode changed after capture");
	a_ready_take: assert property (tx_valid_i && tx_ready_o && clk_en_i |=> !tx_ready_o)
		else $error("ready stayed high after load");
endmodule : spi_port_sva

bind spi_slave_port spi_port_sva u_sva (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
	.port_select_low_i(port_select_low_i), .polarity_strap_pin_i(polarity_strap_pin_i),
	.phase_strap_pin_i(phase_strap_pin_i), .device_serial_out_oe_o(device_serial_out_oe_o),
	.clock_polarity_select_o(clock_polarity_select_o), .clock_phase_select_o(clock_phase_select_o),
	.mode_valid_o(mode_valid_o), .frame_active_o(frame_active_o), .wake_o(wake_o), .rx_valid_o(rx_valid_o),
	.tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o));

//--- verif/host_master_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// serial master on the host side; sole source of the serial clock
// ----------------------------------------------------------------
module host_master_model (
	input wire logic pol_i,
	input wire logic pha_i,
	input wire logic miso_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic mosi_o
);
	initial begin
		cs_n_o = 1'h1;
		sclk_o = 1'h0;
		mosi_o = 1'h0;
	end
	task automatic frame(input int n, input logic [63:0] dout, input realtime half, output logic [63:0] din);
		din = '0;
		sclk_o = pol_i;
		#7.3;
		cs_n_o = 1'h0;
		#40.0;
		for (int i = n * 8 - 1; i >= 0; i--) begin
			if (pha_i) begin
				sclk_o = ~sclk_o;
				mosi_o = dout[i];
				#(half);
				din[i] = miso_i;
				sclk_o = ~sclk_o;
				#(half);
			end else begin
				mosi_o = dout[i];
				#(half);
				din[i] = miso_i;
				sclk_o = ~sclk_o;
				#(half);
				sclk_o = ~sclk_o;
			end
		end
		#50.0;
		cs_n_o = 1'h1;
		mosi_o = ~mosi_o;
	endtask : frame
endmodule : host_master_model

//--- verif/tb_top.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top;
	logic core_clk = 1'h0;
	logic reset_n = 1'h0;
	logic clk_en = 1'h1;
	logic pol_strap = 1'h0;
	logic pha_strap = 1'h0;
	logic tx_valid = 1'h0;
	logic [7:0] tx_data = 8'h00;
	logic sclk, cs_n, mosi, miso_out, miso_oe, mode_pol, mode_pha, mode_valid, frame_active, wake;
	logic rx_valid, tx_ready, underrun;
	logic [7:0] rx_data;
	wire miso_w;
	int err_count = 0;
	int n_compared = 0;
	always #2.5 core_clk = ~core_clk;
	assign miso_w = miso_oe ? miso_out : 1'bz;
	spi_slave_port u_dut (.core_clk_i(core_clk), .reset_n_i(reset_n), .clk_en_i(clk_en), .serial_clock_in_i(sclk),
		.port_select_low_i(cs_n), .host_serial_in_i(mosi), .device_serial_out_o(miso_out),
		.device_serial_out_oe_o(miso_oe), .polarity_strap_pin_i(pol_strap), .phase_strap_pin_i(pha_strap),
		.clock_polarity_select_o(mode_pol), .clock_phase_select_o(mode_pha), .mode_valid_o(mode_valid),
		.frame_active_o(frame_active), .wake_o(wake), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
		.tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .tx_underrun_o(underrun));
	host_master_model u_host (.pol_i(mode_pol), .pha_i(mode_pha), .miso_i(miso_w), .sclk_o(sclk), .cs_n_o(cs_n),
		.mosi_o(mosi));
	task automatic close_out;
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out
	task automatic tick;
		@(posedge core_clk);
		#1;
	endtask : tick
	task automatic wait_for(ref logic sig);
		int k;
		for (k = 0; k < 3000 && sig !== 1'b1; k++) tick();
		if (k == 3000) begin
			err_count++;
			$display("[ERR] %0t wait ran out", $time);
			close_out();
		end
	endtask : wait_for
	task automatic do_reset(input logic p, input logic h);
		tick();
		reset_n = 1'h0;
		pol_strap = p;
		pha_strap = h;
		repeat (20) tick();
		reset_n = 1'h1;
		repeat (3) tick();
		`CHK(mode_valid, 1'b1)
		`CHK({mode_pol, mode_pha}, {p, h})
		`CHK({tx_ready, rx_data, miso_oe}, {1'b1, 8'h00, 1'b0})
		pol_strap = ~p;
		pha_strap = ~h;
		repeat (5) tick();
		`CHK({mode_pol, mode_pha}, {p, h})
	endtask : do_reset
	task automatic load(input logic [7:0] b);
		wait_for(tx_ready);
		tx_data = b;
		tx_valid = 1'h1;
		tick();
		tx_valid = 1'h0;
	endtask : load
	task automatic collect(input logic [15:0] exp);
		for (int j = 0; j < 2; j++) begin
			wait_for(rx_valid);
			`CHK(rx_data, exp[15 - 8 * j -: 8])
			tick();
		end
	endtask : collect
	task automatic xfer(input realtime half, input logic fill);
		logic [63:0] got;
		load(8'hA5);
		fork
			u_host.frame(2, 64'h3CC3, half, got);
			if (fill) load(8'h5A);
			collect(16'h3CC3);
		join
		tick();
		`CHK(got[15:0], fill ? 16'hA55A : 16'hA5A5)
		`CHK(underrun, ~fill)
	endtask : xfer
	task automatic single(input logic [7:0] b);
		logic [63:0] got;
		load(b);
		fork
			begin
				u_host.frame(1, 64'h96, 62.5, got);
				#5.0;
				`CHK(miso_oe, 1'b0)
			end
			begin
				wait_for(wake);
				`CHK({frame_active, miso_oe}, 2'b11)
			end
			begin
				wait_for(rx_valid);
				`CHK(rx_data, 8'h96)
			end
		join
		tick();
		`CHK({got[7:0], underrun}, {b, 1'b0})
		clk_en = 1'h0;
		tx_data = 8'h00;
		tx_valid = 1'h1;
		repeat (3) tick();
		tx_valid = 1'h0;
		clk_en = 1'h1;
		tick();
		`CHK(tx_ready, 1'b1)
	endtask : single
	initial begin
		for (int m = 0; m < 4; m++) begin
			do_reset(m[1], m[0]);
			xfer(62.5, 1'b1);
			xfer(62.5, 1'b0);
			xfer(62.5, 1'b1);
			single(8'hC3);
		end
		close_out();
	end
endmodule : tb_top
